/* ecm_pkg.sv */
/*
 error code memory and status led block: shared constants and types.
 assumes a classic wishbone slave with 32-bit data and one 100 MHz clock.
*/
package ecm_pkg;
   localparam int          ECM_NCODES        = 5;
   localparam logic [2:0]  ECM_CODE_NONE     = 3'h0;
   localparam logic [2:0]  ECM_CODE_OVERTRIG = 3'h1;
   localparam logic [2:0]  ECM_CODE_USERSET  = 3'h2;
   localparam logic [2:0]  ECM_CODE_PARAM    = 3'h3;
   localparam logic [2:0]  ECM_CODE_OVERTEMP = 3'h4;
   localparam logic [2:0]  ECM_CODE_POWER    = 3'h5;
   // register byte offsets
   localparam logic [3:0]  ECM_ADR_LAST      = 4'h0;
   localparam logic [3:0]  ECM_ADR_CLEAR     = 4'h4;
   localparam logic [3:0]  ECM_ADR_IRQ_STAT  = 4'h8;
   localparam logic [3:0]  ECM_ADR_IRQ_MASK  = 4'hc;
   localparam logic [31:0] ECM_UNMAPPED_DATA = 32'h0000_0000;
   // flash half period
   localparam int          ECM_CLK_HZ        = 100_000_000;
   localparam int          ECM_FLASH_HALF_MS = 250;
   localparam int          ECM_FLASH_CYC     = ECM_CLK_HZ / 1000 * ECM_FLASH_HALF_MS;
   localparam int          ECM_FLASH_W       = 25;

   typedef enum logic [2:0] {
      ECM_LED_BOOT, ECM_LED_INTERNAL, ECM_LED_CORR, ECM_LED_TRIGWAIT, ECM_LED_OK
   } ecm_led_mode_t;

   typedef struct packed {
      logic red;
      logic green;
   } ecm_led_t;

   typedef struct packed {
      logic overtrig;
      logic userset_fail;
      logic param_bad;
      logic overtemp;
      logic power_over_video_link;
   } ecm_err_ev_t;
endpackage : ecm_pkg

/* ecm_error_led.sv */
/*
 error memory (one entry per code, newest-first stack), status leds,
 wishbone register slave and interrupt.
 assumes error event inputs are same-clock pulses or levels; repeated
 events of a recorded code are absorbed.
*/
`timescale 1ns/1ps
module ecm_error_led #(
   parameter int FLASH_CYC = ecm_pkg::ECM_FLASH_CYC
) (
   // clock, reset, enable
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   // wishbone slave
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [3:0]          adr_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   output logic                     ack_o,
   // device condition inputs
   input  wire logic                boot_done_i,
   input  wire logic                internal_fault_i,
   input  wire logic                hw_trig_cfg_i,
   input  wire logic                trig_seen_i,
   input  wire logic                line_trig_i,
   input  wire logic                wait_line_trig_i,
   input  wire logic                userset_fail_i,
   input  wire logic                param_bad_i,
   input  wire logic                overtemp_i,
   input  wire logic                high_res_model_i,
   input  wire logic                power_over_video_link_i,
   // outputs
   output logic                     acq_stop_o,
   output ecm_pkg::ecm_led_t        led_o,
   output logic                     irq_o
);
   import ecm_pkg::*;

   localparam int DEPTH = ECM_NCODES;

   typedef struct packed {
      logic [DEPTH-1:0][2:0] stack;
      logic [2:0]            cnt;
      logic [DEPTH-1:0]      present;
      logic [DEPTH-1:0]      irq_stat;
      logic [DEPTH-1:0]      irq_mask;
      logic [ECM_FLASH_W-1:0] flash_cnt;
      logic                  phase;
      logic                  acq_stop;
      ecm_led_t              led;
      logic                  irq;
      logic [31:0]           dat;
      logic                  ack;
   } ecm_state_t;

   ecm_state_t    st_reg;
   ecm_state_t    st_next;
   ecm_err_ev_t   ev;
   ecm_led_mode_t mode;
   logic          wr;
   logic          rd;
   // assertion helpers, same clock, read only by the checks below
   logic [DEPTH-1:0] evv_w;
   logic          pop_fault_code_cmd;

   assign evv_w = {ev.power_over_video_link, ev.overtemp, ev.param_bad,
                   ev.userset_fail, ev.overtrig};
   assign pop_fault_code_cmd = wr && adr_i == ECM_ADR_CLEAR && sel_i[0] && dat_i[0]
                               && st_reg.cnt != 3'h0;

   function automatic logic [2:0] top_code(input logic [DEPTH-1:0][2:0] s,
                                           input logic [2:0] n);
      top_code = (n == 3'h0) ? ECM_CODE_NONE : s[n - 3'h1];
   endfunction : top_code

   // event detection per code
   always_comb begin
      ev.overtrig              = line_trig_i && !wait_line_trig_i;
      ev.userset_fail          = userset_fail_i;
      ev.param_bad             = param_bad_i;
      ev.overtemp              = overtemp_i;
      ev.power_over_video_link = high_res_model_i && power_over_video_link_i;
   end

   assign wr = cyc_i && stb_i && we_i && !st_reg.ack;
   assign rd = cyc_i && stb_i && !we_i && !st_reg.ack;

   always_comb begin
      logic [DEPTH-1:0] evv;
      logic [2:0]       code;
      logic [2:0]       top;
      st_next = st_reg;
      evv     = {ev.power_over_video_link, ev.overtemp, ev.param_bad,
                 ev.userset_fail, ev.overtrig};
      code    = 3'h0;
      top     = 3'h0;
      mode    = ECM_LED_OK;
      st_next.ack = 1'b0;
      // clear pops newest entry first so new events push after it
      if (wr && adr_i == ECM_ADR_CLEAR && sel_i[0] && dat_i[0] && st_reg.cnt != 3'h0) begin
         top = top_code(st_reg.stack, st_reg.cnt);
         st_next.present[top - 3'h1] = 1'b0;
         st_next.cnt = st_reg.cnt - 3'h1;
      end
      // one code per cycle is pushed; lowest index first, others retry
      for (int i = 0; i < DEPTH; i++) begin
         if (evv[i] && !st_next.present[i] && code == 3'h0) begin
            code = 3'(i + 1);
            st_next.stack[st_next.cnt] = code;
            st_next.cnt                = st_next.cnt + 3'h1;
            st_next.present[i]         = 1'b1;
         end
      end
      // irq status: set wins over write-one-to-clear
      if (wr && adr_i == ECM_ADR_IRQ_STAT && sel_i[0])
         st_next.irq_stat = st_reg.irq_stat & ~dat_i[DEPTH-1:0];
      st_next.irq_stat = st_next.irq_stat | evv;
      if (wr && adr_i == ECM_ADR_IRQ_MASK && sel_i[0])
         st_next.irq_mask = dat_i[DEPTH-1:0];
      st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
      st_next.acq_stop = st_reg.acq_stop | ev.overtemp;
      if (cyc_i && stb_i && !st_reg.ack) begin
         st_next.ack = 1'b1;
         st_next.dat = ECM_UNMAPPED_DATA;
         if (rd) begin
            unique case (adr_i)
               ECM_ADR_LAST:     st_next.dat = {29'h0, top_code(st_reg.stack, st_reg.cnt)};
               ECM_ADR_IRQ_STAT: st_next.dat = {27'h0, st_reg.irq_stat};
               ECM_ADR_IRQ_MASK: st_next.dat = {27'h0, st_reg.irq_mask};
               default:          st_next.dat = ECM_UNMAPPED_DATA;
            endcase
         end
      end
      // flash timebase
      if (st_reg.flash_cnt == ECM_FLASH_W'(FLASH_CYC - 1)) begin
         st_next.flash_cnt = '0;
         st_next.phase     = !st_reg.phase;
      end else begin
         st_next.flash_cnt = st_reg.flash_cnt + 1'b1;
      end
      // led priority
      if (!boot_done_i)                    mode = ECM_LED_BOOT;
      else if (internal_fault_i)           mode = ECM_LED_INTERNAL;
      else if (st_next.cnt != 3'h0)        mode = ECM_LED_CORR;
      else if (hw_trig_cfg_i && !trig_seen_i) mode = ECM_LED_TRIGWAIT;
      else                                 mode = ECM_LED_OK;
      unique case (mode)
         ECM_LED_BOOT:     st_next.led = '{red: 1'b1, green: 1'b1};
         ECM_LED_INTERNAL: st_next.led = '{red: st_reg.phase, green: 1'b0};
         ECM_LED_CORR:     st_next.led = '{red: st_reg.phase, green: !st_reg.phase};
         ECM_LED_TRIGWAIT: st_next.led = '{red: 1'b0, green: st_reg.phase};
         ECM_LED_OK:       st_next.led = '{red: 1'b0, green: 1'b1};
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg     <= '0;
         st_reg.led <= '{red: 1'b1, green: 1'b1};
      end else if (ce_i) begin
         st_reg <= st_next;
      end
   end

   assign dat_o      = st_reg.dat;
   assign ack_o      = st_reg.ack;
   assign led_o      = st_reg.led;
   assign irq_o      = st_reg.irq;
   assign acq_stop_o = st_reg.acq_stop;

   AST_EMPTY_READS_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rd && adr_i == ECM_ADR_LAST && st_reg.cnt == 3'h0) |=> dat_o == 32'h0)
      else $error("empty memory did not read zero");
   AST_OVERTRIG_REC: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && line_trig_i && !wait_line_trig_i) |=> st_reg.present[0])
      else $error("overtrigger not recorded");
   AST_TEMP_STOP: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && overtemp_i) |=> acq_stop_o && st_reg.present[3])
      else $error("overtemp did not stop acquisition");
   AST_COUNT_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
      st_reg.cnt == 3'($countones(st_reg.present)))
      else $error("entry count differs from present codes");
   AST_CLEAR_POPS: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && adr_i == ECM_ADR_CLEAR && sel_i[0] && dat_i[0] && st_reg.cnt != 3'h0)
      |=> !st_reg.present[$past(top_code(st_reg.stack, st_reg.cnt)) - 3'h1] || $past(|evv_w))
      else $error("clear did not remove newest code");
   AST_BOOT_BOTH: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !boot_done_i) |=> led_o == '{red: 1'b1, green: 1'b1})
      else $error("boot leds wrong");
   AST_OK_GREEN: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && boot_done_i && !internal_fault_i && st_reg.cnt == 3'h0 && !(|evv_w)
       && !hw_trig_cfg_i) |=> led_o == '{red: 1'b0, green: 1'b1})
      else $error("ok state not steady green");
   AST_ALT_FLASH: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && boot_done_i && !internal_fault_i && st_reg.cnt != 3'h0 && !wr)
      |=> led_o.red != led_o.green)
      else $error("alternating flash broken");
   AST_INTERNAL_NO_GREEN: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && boot_done_i && internal_fault_i) |=> !led_o.green)
      else $error("internal fault shows green");


   // bus handshake: one ack per request, never held
   AST_ACK_AFTER_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && cyc_i && stb_i && !ack_o) |=> ack_o)
      else $error("request not acknowledged");

   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && ack_o) |=> !ack_o)
      else $error("ack held longer than one cycle");

   // clock enable low must freeze every bit of state
   AST_CE_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(st_reg))
      else $error("state moved while clock enable low");

   // lowest pending code wins a cycle, so only guard the clean cases
   AST_USERSET_REC: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && userset_fail_i && !evv_w[0]) |=> st_reg.present[1])
      else $error("user set failure not recorded");

   AST_PARAM_REC: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && param_bad_i && evv_w[1:0] == 2'h0) |=> st_reg.present[2])
      else $error("invalid parameter not recorded");

   AST_POWER_REC: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && evv_w[4] && evv_w[3:0] == 4'h0) |=> st_reg.present[4])
      else $error("video link power not recorded");

   // an entry can only appear through its own event
   for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      AST_NO_SPURIOUS: assert property (@(posedge clk_i) disable iff (rst_i)
         (!st_reg.present[g] && !(ce_i && evv_w[g])) |=> !st_reg.present[g])
         else $error("entry recorded without its event");
   end

   AST_STAT_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && |evv_w) |=> (st_reg.irq_stat & $past(evv_w)) == $past(evv_w))
      else $error("event did not set its status bit");

   AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == |(st_reg.irq_stat & st_reg.irq_mask))
      else $error("interrupt level differs from masked status");

   AST_MASK_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
      !(ce_i && wr && adr_i == ECM_ADR_IRQ_MASK) |=> $stable(st_reg.irq_mask))
      else $error("mask changed without a write");

   // reading never shrinks the memory
   AST_READ_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && rd) |=> st_reg.cnt >= $past(st_reg.cnt))
      else $error("read removed an entry");

   AST_CLEAR_DEC: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && pop_fault_code_cmd && !(|evv_w)) |=> st_reg.cnt == $past(st_reg.cnt) - 3'h1)
      else $error("clear did not drop exactly one entry");

   AST_EMPTY_CLEAR_IGN: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wr && adr_i == ECM_ADR_CLEAR && st_reg.cnt == 3'h0 && !(|evv_w))
      |=> st_reg.cnt == 3'h0)
      else $error("clear on empty memory changed it");

   AST_CNT_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
      st_reg.cnt <= 3'(DEPTH))
      else $error("more entries than distinct codes");

   // acquisition stop is sticky until reset
   AST_ACQ_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      acq_stop_o |=> acq_stop_o)
      else $error("acquisition stop released");

   AST_NO_STOP_COOL: assert property (@(posedge clk_i) disable iff (rst_i)
      (!acq_stop_o && !(ce_i && overtemp_i)) |=> !acq_stop_o)
      else $error("acquisition stopped without overheating");

   AST_TRIGWAIT_NO_RED: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && boot_done_i && !internal_fault_i && st_reg.cnt == 3'h0 && !(|evv_w)
       && hw_trig_cfg_i && !trig_seen_i) |=> !led_o.red)
      else $error("trigger wait shows red");

   AST_INTERNAL_OVER_CORR: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && boot_done_i && internal_fault_i && st_reg.cnt != 3'h0)
      |=> !led_o.green)
      else $error("correctable flash beat internal fault");

   // last pop with nothing else pending lands on steady green
   AST_DRAINED_OK: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && pop_fault_code_cmd && st_reg.cnt == 3'h1 && !(|evv_w) && boot_done_i
       && !internal_fault_i && !hw_trig_cfg_i) |=> led_o == '{red: 1'b0, green: 1'b1})
      else $error("leds still flashing after drain");

   // timebase wraps before reaching the half period
   AST_FLASH_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
      st_reg.flash_cnt <= ECM_FLASH_W'(FLASH_CYC - 1))
      else $error("flash counter out of range");

   COV_TWO_CODES: cover property (@(posedge clk_i) disable iff (rst_i) st_reg.cnt == 3'h2);
   COV_STOPPED:   cover property (@(posedge clk_i) disable iff (rst_i) acq_stop_o);
   COV_DRAIN:     cover property (@(posedge clk_i) disable iff (rst_i)
      st_reg.cnt == 3'h1 ##1 st_reg.cnt == 3'h0);
   COV_IRQ:       cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
endmodule : ecm_error_led

/* testbench.sv */
/*
 self-checking bench for the error code memory and status led block.
 assumes one 100 MHz clock, same-clock event inputs, flash half period of 4 cycles.
*/
`timescale 1ns/1ps
module testbench;
   import ecm_pkg::*;
   logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i;
   logic [3:0]  adr_i, sel_i;
   logic [31:0] dat_i, dat_o, rdat;
   logic        ack_o, acq_stop_o, irq_o, boot_done_i, internal_fault_i, hw_trig_cfg_i;
   logic        trig_seen_i, line_trig_i, wait_line_trig_i, userset_fail_i, param_bad_i;
   logic        overtemp_i, high_res_model_i, power_over_video_link_i;
   ecm_led_t    led;
   int          errors, total_checks, cycles;
   logic [2:0]  drain [6] = '{3'h4, 3'h2, 3'h5, 3'h1, 3'h3, 3'h0};

   ecm_error_led #(.FLASH_CYC(4)) ecm_error_led_inst (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .boot_done_i(boot_done_i),
      .internal_fault_i(internal_fault_i), .hw_trig_cfg_i(hw_trig_cfg_i),
      .trig_seen_i(trig_seen_i), .line_trig_i(line_trig_i),
      .wait_line_trig_i(wait_line_trig_i), .userset_fail_i(userset_fail_i),
      .param_bad_i(param_bad_i), .overtemp_i(overtemp_i), .high_res_model_i(high_res_model_i),
      .power_over_video_link_i(power_over_video_link_i), .acq_stop_o(acq_stop_o),
      .led_o(led), .irq_o(irq_o));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task results;
      if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   // generous ceiling: the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         results();
      end
   end

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one classic cycle; waits on ack with no assumed latency
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rdat = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask : bus

   // sample led for three flash half periods: {red moved, green moved, equal, red lit, green lit}
   task obs(input logic [4:0] exp, input string nm);
      logic [4:0] v;
      ecm_led_t   p;
      repeat (2) @(posedge clk_i);
      v = 5'h00;
      p = led;
      repeat (12) begin
         @(posedge clk_i);
         v |= {led.red != p.red, led.green != p.green, led.red == led.green, led.red, led.green};
         p = led;
      end
      chk(nm, {27'h0, v}, {27'h0, exp});
   endtask : obs

   // one-cycle event pulse, then a spare cycle so events never coincide
   task ev(input int k);
      @(posedge clk_i);
      case (k)
         1: line_trig_i <= 1'b1;
         2: userset_fail_i <= 1'b1;
         3: param_bad_i <= 1'b1;
         4: overtemp_i <= 1'b1;
         default: power_over_video_link_i <= 1'b1;
      endcase
      @(posedge clk_i);
      {line_trig_i, userset_fail_i, param_bad_i, overtemp_i, power_over_video_link_i} <= 5'h00;
      @(posedge clk_i);
   endtask : ev

   task led_states;
      obs(5'b00111, "led_boot");
      boot_done_i <= 1'b1;
      obs(5'b00001, "led_ok");
      hw_trig_cfg_i <= 1'b1;
      obs(5'b01101, "led_trigwait");
      trig_seen_i <= 1'b1;
      obs(5'b00001, "led_trig_present");
   endtask : led_states

   // enable low: a new fault must not reach the leds
   task ce_freeze;
      ce_i             <= 1'b0;
      internal_fault_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("ce_freeze", {30'h0, led}, 32'h1);
      ce_i             <= 1'b1;
      internal_fault_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : ce_freeze

   task record_events;
      wait_line_trig_i <= 1'b1;
      ev(1);
      wait_line_trig_i <= 1'b0;
      ev(5);
      bus(1'b0, ECM_ADR_LAST, 32'h0);
      chk("no_false_code", rdat, 32'h0);
      high_res_model_i <= 1'b1;
      ev(3); ev(1); ev(3); ev(5); ev(2); ev(4);
      chk("acq_stop", {31'h0, acq_stop_o}, 32'h1);
      bus(1'b0, ECM_ADR_IRQ_STAT, 32'h0);
      chk("irq_stat", rdat, 32'h1f);
      chk("irq_masked", {31'h0, irq_o}, 32'h0);
      bus(1'b1, ECM_ADR_IRQ_MASK, 32'h1f);
      repeat (2) @(posedge clk_i);
      chk("irq_on", {31'h0, irq_o}, 32'h1);
      bus(1'b1, ECM_ADR_IRQ_STAT, 32'h1f);
      repeat (2) @(posedge clk_i);
      chk("irq_off", {31'h0, irq_o}, 32'h0);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", rdat, ECM_UNMAPPED_DATA);
   endtask : record_events

   task fault_and_drain;
      internal_fault_i <= 1'b1;
      obs(5'b10110, "led_internal");
      internal_fault_i <= 1'b0;
      obs(5'b11011, "led_corr");
      bus(1'b0, ECM_ADR_LAST, 32'h0);
      bus(1'b0, ECM_ADR_LAST, 32'h0);
      chk("read_keeps", rdat, 32'h4);
      // the final clear hits an empty memory and must be ignored
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, ECM_ADR_LAST, 32'h0);
         chk("last_error", rdat, {29'h0, drain[i]});
         bus(1'b1, ECM_ADR_CLEAR, 32'h1);
      end
      bus(1'b0, ECM_ADR_LAST, 32'h0);
      chk("empty_after", rdat, 32'h0);
      obs(5'b00001, "led_after_drain");
   endtask : fault_and_drain

   initial begin
      {rst_i, ce_i, sel_i} = 6'b111111;
      {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
      {boot_done_i, internal_fault_i, hw_trig_cfg_i, trig_seen_i, line_trig_i} = 5'h00;
      {wait_line_trig_i, userset_fail_i, param_bad_i, overtemp_i} = 4'h0;
      {high_res_model_i, power_over_video_link_i} = 2'b00;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      led_states();
      ce_freeze();
      record_events();
      fault_and_drain();
      results();
   end
endmodule : testbench
